// ==== core/lane_ctrl_pkg.sv ====
// Constants for lane squelch and power control
//
// Behaviour
// - Low-power pin high puts the module into its reduced power state.
// - Pin plus override, set and high-class bits of byte 0x5D limit power.
// - Each receive lane with optical loss has its data output muted, independently.
// - Receive muting is enabled after reset.
// - Host may defeat receive muting through an optional control bit.
// - Transmit electrical loss mutes that lane's optical output and sets its flag.
// - Transmit loss detection and muting are optional but follow the behaviour.
// - Transmit muting, where present, is enabled after reset.
// - Host may defeat transmit muting through an optional control bit.
// - Transmit mute disables laser or reduces amplitude, as selected.
package lane_ctrl_pkg;

   // ---------------------------------------------------------------
   // Geometry
   // ---------------------------------------------------------------
   localparam int unsigned LANES = 4;

   // ---------------------------------------------------------------
   // Register offsets
   // ---------------------------------------------------------------
   localparam logic [7:0] POWER_CLASS_CONTROL_OFS = 8'h5d;
   localparam logic [7:0] MUTE_CONTROL_OFS = 8'h70;
   localparam logic [7:0] LANE_STATUS_OFS = 8'h71;

   // ---------------------------------------------------------------
   // Field positions
   // ---------------------------------------------------------------
   localparam int unsigned PWR_OVERRIDE_BIT = 0;
   localparam int unsigned PWR_SET_BIT = 1;
   localparam int unsigned PWR_HIGH_CLASS_BIT = 2;
   localparam int unsigned RX_DEFEAT_BIT = 0;
   localparam int unsigned TX_DEFEAT_BIT = 1;
   localparam int unsigned TX_STYLE_BIT = 2;
   localparam int unsigned STATUS_RX_MUTE_LSB = 4;

   // ---------------------------------------------------------------
   // Reset values
   // ---------------------------------------------------------------
   localparam logic [2:0] POWER_CLASS_RESET = 3'h0;
   localparam logic [2:0] MUTE_CONTROL_RESET = 3'h0;
   localparam logic [7:0] READ_RESET = 8'h00;
   localparam logic [3:0] FLAG_RESET = 4'h0;
   // Safe state while the controller is held in reset
   localparam logic LOW_POWER_RESET = 1'b1;
   localparam logic HIGH_CLASS_RESET = 1'b0;

endpackage : lane_ctrl_pkg

// ==== core/lane_gate.sv ====
// One lane's registered mute decision
module lane_gate (
   // Clock and reset
   input wire logic sys_clk_i,
   input wire logic reset_n_i,
   // Lane control
   input wire logic impl_i,
   input wire logic loss_i,
   input wire logic defeat_i,
   input wire logic style_amp_i,
   // Mute outputs
   output logic off_o,
   output logic amp_o
);

   typedef struct packed {
      logic off;
      logic amp;
   } gate_state_t;

   gate_state_t st_q;
   gate_state_t st_d;
   logic mute;

   // ---------------------------------------------------------------
   // Decision
   // ---------------------------------------------------------------
   always_comb begin
      // Releases on the clock edge after the loss clears
      mute = impl_i & loss_i & ~defeat_i;
      // Laser off or reduced swing, never both
      st_d.off = mute & ~style_amp_i;
      st_d.amp = mute & style_amp_i;
   end

   always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign off_o = st_q.off;
   assign amp_o = st_q.amp;

endmodule : lane_gate

// ==== core/lane_squelch_power_control.sv ====
// Lane squelch and power arbitration for one cable end
module lane_squelch_power_control #(
   parameter bit TX_SQUELCH_IMPL = 1'b1,
   parameter bit RX_DEFEAT_IMPL = 1'b1,
   parameter bit TX_DEFEAT_IMPL = 1'b1
) (
   // Clock and reset
   input wire logic sys_clk_i,
   input wire logic reset_n_i,
   // Register port from the management controller
   input wire logic [7:0] reg_addr_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   output logic [7:0] reg_rdata_o,
   output logic reg_rvalid_o,
   // Low-power pin
   input wire logic low_power_pin_i,
   // Lane detectors
   input wire logic [3:0] rx_optical_loss_i,
   input wire logic [3:0] tx_elec_loss_i,
   // Lane controls
   output logic [3:0] rx_mute_o,
   output logic [3:0] tx_laser_off_o,
   output logic [3:0] tx_amp_reduce_o,
   output logic [3:0] tx_input_loss_flag_o,
   // Power state
   output logic low_power_o,
   output logic high_class_en_o
);

   typedef struct packed {
      logic [2:0] power;
      logic [2:0] ctrl;
      logic [3:0] flag;
      logic [7:0] rdata;
      logic rvalid;
      logic low_power;
      logic high_class;
   } top_state_t;

   top_state_t st_q;
   top_state_t st_d;
   logic rx_defeat;
   logic tx_defeat;
   logic [3:0] tx_loss_seen;
   logic ctrl_written_q;

   // ---------------------------------------------------------------
   // Decode helper
   // ---------------------------------------------------------------
   function automatic logic hit(input logic [7:0] addr, input logic [7:0] ofs);
      hit = (addr == ofs);
   endfunction : hit

   assign rx_defeat = RX_DEFEAT_IMPL & st_q.ctrl[lane_ctrl_pkg::RX_DEFEAT_BIT];
   assign tx_defeat = TX_DEFEAT_IMPL & st_q.ctrl[lane_ctrl_pkg::TX_DEFEAT_BIT];
   // Detector omitted entirely when the option is off
   assign tx_loss_seen = TX_SQUELCH_IMPL ? tx_elec_loss_i : 4'h0;

   // ---------------------------------------------------------------
   // Registers and power arbitration
   // ---------------------------------------------------------------
   always_comb begin
      st_d = st_q;
      st_d.rvalid = 1'b0;
      if (reg_wr_i) begin
         if (hit(reg_addr_i, lane_ctrl_pkg::POWER_CLASS_CONTROL_OFS)) begin
            st_d.power = reg_wdata_i[2:0];
         end else if (hit(reg_addr_i, lane_ctrl_pkg::MUTE_CONTROL_OFS)) begin
            st_d.ctrl = reg_wdata_i[2:0];
         end
      end
      // Flags clear on status read; a loss in the same cycle wins
      if (reg_rd_i) begin
         st_d.rvalid = 1'b1;
         if (hit(reg_addr_i, lane_ctrl_pkg::POWER_CLASS_CONTROL_OFS)) begin
            st_d.rdata = {5'h00, st_q.power};
         end else if (hit(reg_addr_i, lane_ctrl_pkg::MUTE_CONTROL_OFS)) begin
            st_d.rdata = {5'h00, st_q.ctrl[2], tx_defeat, rx_defeat};
         end else if (hit(reg_addr_i, lane_ctrl_pkg::LANE_STATUS_OFS)) begin
            st_d.rdata = {rx_mute_o, st_q.flag};
            st_d.flag = 4'h0;
         end else begin
            st_d.rdata = lane_ctrl_pkg::READ_RESET;
         end
      end
      st_d.flag = st_d.flag | tx_loss_seen;
      // Override selects the software bit in place of the pin
      if (st_q.power[lane_ctrl_pkg::PWR_OVERRIDE_BIT]) begin
         st_d.low_power = st_q.power[lane_ctrl_pkg::PWR_SET_BIT];
      end else begin
         st_d.low_power = low_power_pin_i;
      end
      // Upper classes only when high power is granted
      st_d.high_class = st_q.power[lane_ctrl_pkg::PWR_HIGH_CLASS_BIT] & ~st_d.low_power;
   end

   always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         st_q.power <= lane_ctrl_pkg::POWER_CLASS_RESET;
         st_q.ctrl <= lane_ctrl_pkg::MUTE_CONTROL_RESET;
         st_q.flag <= lane_ctrl_pkg::FLAG_RESET;
         st_q.rdata <= lane_ctrl_pkg::READ_RESET;
         st_q.rvalid <= 1'b0;
         st_q.low_power <= lane_ctrl_pkg::LOW_POWER_RESET;
         st_q.high_class <= lane_ctrl_pkg::HIGH_CLASS_RESET;
      end else begin
         st_q <= st_d;
      end
   end

   // ---------------------------------------------------------------
   // Lane gates
   // ---------------------------------------------------------------
   for (genvar g = 0; g < lane_ctrl_pkg::LANES; g++) begin : g_lane
      // Each lane decides alone
      lane_gate u_rx (
         .sys_clk_i(sys_clk_i),
         .reset_n_i(reset_n_i),
         .impl_i(1'b1),
         .loss_i(rx_optical_loss_i[g]),
         .defeat_i(rx_defeat),
         .style_amp_i(1'b0),
         .off_o(rx_mute_o[g]),
         .amp_o()
      );
      lane_gate u_tx (
         .sys_clk_i(sys_clk_i),
         .reset_n_i(reset_n_i),
         .impl_i(TX_SQUELCH_IMPL),
         .loss_i(tx_elec_loss_i[g]),
         .defeat_i(tx_defeat),
         .style_amp_i(st_q.ctrl[lane_ctrl_pkg::TX_STYLE_BIT]),
         .off_o(tx_laser_off_o[g]),
         .amp_o(tx_amp_reduce_o[g])
      );
   end

   assign reg_rdata_o = st_q.rdata;
   assign reg_rvalid_o = st_q.rvalid;
   assign tx_input_loss_flag_o = st_q.flag;
   assign low_power_o = st_q.low_power;
   assign high_class_en_o = st_q.high_class;

   // ---------------------------------------------------------------
   // Assertion helpers
   // ---------------------------------------------------------------
   // Tracks whether the mute control was ever written since reset
   always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         ctrl_written_q <= 1'b0;
      end else if (reg_wr_i && hit(reg_addr_i, lane_ctrl_pkg::MUTE_CONTROL_OFS)) begin
         ctrl_written_q <= 1'b1;
      end
   end

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   a_pin_low_power: assert property (
      @(posedge sys_clk_i) disable iff (!reset_n_i)
      (!st_q.power[0] && low_power_pin_i) |=> low_power_o)
      else $error("pin high did not enter low power");

   a_override_select: assert property (
      @(posedge sys_clk_i) disable iff (!reset_n_i)
      st_q.power[0] |=> (low_power_o == $past(st_q.power[1])))
      else $error("override did not follow power set bit");

   a_high_class_gate: assert property (
      @(posedge sys_clk_i) disable iff (!reset_n_i)
      high_class_en_o |-> (!low_power_o && $past(st_q.power[2])))
      else $error("high class granted while not allowed");

   a_rx_mute_loss: assert property (
      @(posedge sys_clk_i) disable iff (!reset_n_i)
      !rx_defeat |=> ((rx_mute_o & $past(rx_optical_loss_i)) == $past(rx_optical_loss_i)))
      else $error("receive lane with loss not muted");

   a_rx_release: assert property (
      @(posedge sys_clk_i) disable iff (!reset_n_i)
      1'b1 |=> ((rx_mute_o & ~$past(rx_optical_loss_i)) == 4'h0))
      else $error("receive mute held without loss");

   a_mute_default: assert property (
      @(posedge sys_clk_i) disable iff (!reset_n_i)
      !ctrl_written_q |-> (!rx_defeat && !tx_defeat))
      else $error("mute defeated without a host write");

   a_rx_defeat: assert property (
      @(posedge sys_clk_i) disable iff (!reset_n_i)
      rx_defeat [*2] |-> (rx_mute_o == 4'h0))
      else $error("receive mute active while defeated");

   a_tx_mute_flag: assert property (
      @(posedge sys_clk_i) disable iff (!reset_n_i)
      (TX_SQUELCH_IMPL && !tx_defeat) |=>
         (((tx_laser_off_o | tx_amp_reduce_o) & $past(tx_elec_loss_i)) == $past(tx_elec_loss_i)
          && (tx_input_loss_flag_o & $past(tx_elec_loss_i)) == $past(tx_elec_loss_i)))
      else $error("transmit loss not muted or not flagged");

   a_tx_absent: assert property (
      @(posedge sys_clk_i) disable iff (!reset_n_i)
      !TX_SQUELCH_IMPL |-> (tx_laser_off_o == 4'h0 && tx_input_loss_flag_o == 4'h0))
      else $error("transmit squelch active though omitted");

   a_tx_defeat: assert property (
      @(posedge sys_clk_i) disable iff (!reset_n_i)
      tx_defeat [*2] |-> ((tx_laser_off_o | tx_amp_reduce_o) == 4'h0))
      else $error("transmit mute active while defeated");

   a_tx_style: assert property (
      @(posedge sys_clk_i) disable iff (!reset_n_i)
      ((tx_laser_off_o & tx_amp_reduce_o) == 4'h0)
      and (st_q.ctrl[2] && $stable(st_q.ctrl[2]) |-> tx_laser_off_o == 4'h0))
      else $error("transmit mute style wrong");

   a_flag_sticky: assert property (
      @(posedge sys_clk_i) disable iff (!reset_n_i)
      !(reg_rd_i && hit(reg_addr_i, lane_ctrl_pkg::LANE_STATUS_OFS)) |=>
         ((tx_input_loss_flag_o & $past(tx_input_loss_flag_o)) == $past(tx_input_loss_flag_o)))
      else $error("loss flag dropped without a status read");

endmodule : lane_squelch_power_control

// ==== verif/host_model.sv ====
// Host model driving the register port and the low-power pin
module host_model (
   // Clock
   input wire logic sys_clk_i,
   // Register port toward the device
   output logic [7:0] reg_addr_o,
   output logic [7:0] reg_wdata_o,
   output logic reg_wr_o,
   output logic reg_rd_o,
   // Low-power pin
   output logic low_power_pin_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] exp_q[$];
   initial begin
      reg_addr_o = 8'h00;
      reg_wdata_o = 8'h00;
      reg_wr_o = 1'b0;
      reg_rd_o = 1'b0;
      low_power_pin_o = 1'b0;
   end
   // Released bus shows inverted values so stale data never matches
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge sys_clk_i);
      reg_addr_o <= a;
      reg_wdata_o <= d;
      reg_wr_o <= 1'b1;
      @(posedge sys_clk_i);
      reg_wr_o <= 1'b0;
      reg_addr_o <= ~a;
      reg_wdata_o <= ~d;
   endtask : wr_reg
   task automatic rd_reg(input logic [7:0] a, input logic [7:0] e);
      @(posedge sys_clk_i);
      reg_addr_o <= a;
      reg_rd_o <= 1'b1;
      exp_q.push_back(e);
      @(posedge sys_clk_i);
      reg_rd_o <= 1'b0;
      reg_addr_o <= ~a;
   endtask : rd_reg
   task automatic set_pin(input logic p);
      @(posedge sys_clk_i);
      low_power_pin_o <= p;
   endtask : set_pin
endmodule : host_model

// ==== verif/lane_squelch_power_control_tb.sv ====
// Self-checking bench for lane squelch and power control
module lane_squelch_power_control_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic sys_clk_i = 1'b0;
   logic reset_n_i = 1'b0;
   logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o, pwr, mctl, stat;
   logic reg_wr_i, reg_rd_i, reg_rvalid_o, low_power_pin_i, low_power_o, high_class_en_o, lo;
   logic [3:0] rx_optical_loss_i = 4'h0;
   logic [3:0] tx_elec_loss_i = 4'h0;
   logic [3:0] rx_mute_o, tx_laser_off_o, tx_amp_reduce_o, tx_input_loss_flag_o, v;
   logic [2:0] b;
   logic [3:0] bare_rx_mute, bare_tx_off, bare_tx_amp, bare_flag;
   int failures = 0;
   int num_checks = 0;
   int cycles = 0;
   int seed = 26;
   always #2.5 sys_clk_i = ~sys_clk_i;
   host_model host (.sys_clk_i(sys_clk_i), .reg_addr_o(reg_addr_i), .reg_wdata_o(reg_wdata_i),
      .reg_wr_o(reg_wr_i), .reg_rd_o(reg_rd_i), .low_power_pin_o(low_power_pin_i));
   lane_squelch_power_control dut (.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .reg_addr_i(reg_addr_i),
      .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
      .reg_rvalid_o(reg_rvalid_o), .low_power_pin_i(low_power_pin_i), .rx_optical_loss_i(rx_optical_loss_i),
      .tx_elec_loss_i(tx_elec_loss_i), .rx_mute_o(rx_mute_o), .tx_laser_off_o(tx_laser_off_o),
      .tx_amp_reduce_o(tx_amp_reduce_o), .tx_input_loss_flag_o(tx_input_loss_flag_o),
      .low_power_o(low_power_o), .high_class_en_o(high_class_en_o));
   // Minimal build: no transmit squelch, no defeat controls
   lane_squelch_power_control #(.TX_SQUELCH_IMPL(1'b0), .RX_DEFEAT_IMPL(1'b0), .TX_DEFEAT_IMPL(1'b0)) dut_bare (
      .sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
      .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(), .reg_rvalid_o(),
      .low_power_pin_i(low_power_pin_i), .rx_optical_loss_i(rx_optical_loss_i),
      .tx_elec_loss_i(tx_elec_loss_i), .rx_mute_o(bare_rx_mute), .tx_laser_off_o(bare_tx_off),
      .tx_amp_reduce_o(bare_tx_amp), .tx_input_loss_flag_o(bare_flag), .low_power_o(), .high_class_en_o());
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      num_checks++;
      if (got !== exp) begin
         failures++;
         $display("[ERR] %0t mismatch got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task automatic settle();
      @(posedge sys_clk_i);
      #1;
   endtask : settle
   task automatic report_and_stop();
      if (failures == 0 && num_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : report_and_stop
   // Read answers are matched against the host's notes in order
   always @(posedge sys_clk_i) begin
      if (reg_rvalid_o === 1'b1) begin
         if (host.exp_q.size() == 0) begin
            failures++;
            $display("[ERR] %0t read answer without a request", $time);
         end else begin
            chk(reg_rdata_o, host.exp_q.pop_front());
         end
      end
   end
   always @(posedge sys_clk_i) begin
      cycles++;
      if (cycles == 3000) begin
         failures++;
         $display("[ERR] %0t run did not finish in time", $time);
         report_and_stop();
      end
   end
   initial begin
      pwr = lane_ctrl_pkg::POWER_CLASS_CONTROL_OFS;
      mctl = lane_ctrl_pkg::MUTE_CONTROL_OFS;
      stat = lane_ctrl_pkg::LANE_STATUS_OFS;
      repeat (8) @(posedge sys_clk_i);
      #1;
      chk({7'h00, low_power_o}, 8'h01);
      repeat (8) @(posedge sys_clk_i);
      reset_n_i <= 1'b1;
      host.rd_reg(pwr, 8'h00);
      host.rd_reg(mctl, 8'h00);
      for (int i = 0; i < 16; i++) begin
         b = i[2:0];
         host.set_pin(i[3]);
         host.wr_reg(pwr, {5'h00, b});
         lo = b[0] ? b[1] : i[3];
         settle();
         chk({7'h00, low_power_o}, {7'h00, lo});
         chk({7'h00, high_class_en_o}, {7'h00, b[2] & ~lo});
         host.rd_reg(pwr, {5'h00, b});
      end
      // Unmapped places read zero and swallow writes
      host.rd_reg(8'hff, 8'h00);
      host.wr_reg(8'h72, 8'hff);
      host.rd_reg(pwr, 8'h07);
      for (int i = 0; i < 8; i++) begin
         host.wr_reg(mctl, {7'h00, i[2]});
         v = 4'($random(seed));
         @(posedge sys_clk_i);
         rx_optical_loss_i <= v;
         settle();
         chk({4'h0, rx_mute_o}, {4'h0, i[2] ? 4'h0 : v});
         chk({4'h0, bare_rx_mute}, {4'h0, v});
         host.rd_reg(stat, {i[2] ? 4'h0 : v, 4'h0});
      end
      @(posedge sys_clk_i);
      rx_optical_loss_i <= 4'h0;
      for (int i = 0; i < 4; i++) begin
         host.wr_reg(mctl, {5'h00, i[0], i[1], 1'b0});
         v = 4'($random(seed)) | 4'h1;
         @(posedge sys_clk_i);
         tx_elec_loss_i <= v;
         settle();
         chk({4'h0, tx_laser_off_o}, {4'h0, (i[0] | i[1]) ? 4'h0 : v});
         chk({4'h0, tx_amp_reduce_o}, {4'h0, (i[0] & ~i[1]) ? v : 4'h0});
         chk({4'h0, tx_input_loss_flag_o}, {4'h0, v});
         chk({bare_tx_off, bare_tx_amp}, 8'h00);
         chk({4'h0, bare_flag}, 8'h00);
         @(posedge sys_clk_i);
         tx_elec_loss_i <= 4'h0;
         settle();
         chk({tx_laser_off_o, tx_amp_reduce_o}, 8'h00);
         host.rd_reg(stat, {4'h0, v});
         host.rd_reg(stat, 8'h00);
      end
      // Mid-run reset with transmit defeat and amplitude style set
      @(posedge sys_clk_i);
      reset_n_i <= 1'b0;
      settle();
      chk({tx_input_loss_flag_o, 3'h0, low_power_o}, 8'h01);
      @(posedge sys_clk_i);
      reset_n_i <= 1'b1;
      host.rd_reg(mctl, 8'h00);
      @(posedge sys_clk_i);
      rx_optical_loss_i <= 4'h5;
      tx_elec_loss_i <= 4'ha;
      settle();
      chk({rx_mute_o, tx_laser_off_o}, 8'h5a);
      chk({bare_rx_mute, bare_tx_off}, 8'h50);
      @(posedge sys_clk_i);
      rx_optical_loss_i <= 4'h0;
      tx_elec_loss_i <= 4'h0;
      host.rd_reg(stat, 8'h0a);
      repeat (3) settle();
      if (host.exp_q.size() != 0) begin
         failures++;
         $display("[ERR] %0t read answers missing", $time);
      end
      report_and_stop();
   end
endmodule : lane_squelch_power_control_tb
